// *** rtl/lsr_pkg.sv ***
// Constants shared by the sensor end and the controller end of the readout link.
// Assumes a single 50 MHz system clock; the sensor clock is derived from it.
package lsr_pkg;

  // ****************************************************************
  // Array geometry
  // ****************************************************************
  localparam int NUM_SEC    = 2;
  localparam int SEC_PIXELS = 64;
  localparam int SEC_LAST   = SEC_PIXELS - 1;
  localparam int IDX_W      = 6;
  localparam int PIX_W      = 8;
  localparam int NSEC_W     = 4;
  localparam int EDGE_W     = 10;
  localparam int EDGE_EXTRA = 1;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ        = 50_000_000;
  localparam int CLK_NS        = 20;
  localparam int SCLK_HZ       = 500_000;
  localparam int SETTLE_NS     = 1000;
  localparam int SCLK_PER_CYC  = CLK_HZ / SCLK_HZ;
  localparam int SCLK_HALF_CYC = SCLK_PER_CYC / 2;
  localparam int SETTLE_CYC    = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PHASE_W       = 7;
  localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(SCLK_PER_CYC - 1);
  localparam logic [PHASE_W-1:0] PHASE_FALL = PHASE_W'(SCLK_HALF_CYC - 1);
  localparam logic [PHASE_W-1:0] PHASE_HALF = PHASE_W'(SCLK_HALF_CYC);
  localparam logic [PHASE_W-1:0] PHASE_SMP  = PHASE_W'(SETTLE_CYC);

  // ****************************************************************
  // Flush and buffering
  // ****************************************************************
  localparam logic [3:0] FLUSH_CYCLES = 4'hc;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W     = 2 * PIX_W + 2;

endpackage

// *** rtl/lsr_link_if.sv ***
// Link between the readout controller and the two-section linear sensor.
// Assumes both ends run on the same core clock; no clocking block.
`timescale 1ns/1ps
interface lsr_link_if
  import lsr_pkg::*;
();
  logic             sclk;
  logic             start_in_sec1;
  logic             start_in_sec2;
  logic             pass_out_sec1;
  logic             pass_out_sec2;
  logic [PIX_W-1:0] pixel_out_sec1;
  logic [PIX_W-1:0] pixel_out_sec2;
  logic             pixel_oe_sec1;
  logic             pixel_oe_sec2;
  logic [PIX_W-1:0] pixel_analog_out;

  // Shared line of the serial arrangement; undriven reads as zero
  assign pixel_analog_out = pixel_oe_sec1 ? pixel_out_sec1 :
                            pixel_oe_sec2 ? pixel_out_sec2 : '0;

  modport sensor (
    input  sclk, start_in_sec1, start_in_sec2,
    output pass_out_sec1, pass_out_sec2, pixel_out_sec1, pixel_out_sec2,
    output pixel_oe_sec1, pixel_oe_sec2
  );

  modport ctrl (
    output sclk, start_in_sec1, start_in_sec2,
    input  pass_out_sec1, pass_out_sec2, pixel_out_sec1, pixel_out_sec2,
    input  pixel_oe_sec1, pixel_oe_sec2, pixel_analog_out
  );
endinterface

// *** rtl/lsr_sensor_end.sv ***
// Sensor end: two 64-pixel sections with shift register, output enable,
// sample-and-hold and per-cycle sense-node reset.
// Assumes sclk and start inputs are synchronous to core_clk and that the
// controller keeps its side of the link timing.
`timescale 1ns/1ps
module lsr_sensor_end
  import lsr_pkg::*;
(
  input  wire logic             core_clk,      // System clock
  input  wire logic             srst,          // Synchronous reset
  lsr_link_if.sensor            link,          // Link to controller
  output logic [IDX_W-1:0]      px_addr_sec1,  // Pixel index, section one
  output logic [IDX_W-1:0]      px_addr_sec2,  // Pixel index, section two
  input  wire logic [PIX_W-1:0] px_level_sec1, // Pixel level, section one
  input  wire logic [PIX_W-1:0] px_level_sec2, // Pixel level, section two
  output logic                  sense_reset    // One-cycle reset pulse
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic                                 sclk_q;
    logic [NUM_SEC-1:0][SEC_PIXELS-1:0]   sr;
    logic [NUM_SEC-1:0][IDX_W-1:0]        idx;
    logic [NUM_SEC-1:0][PIX_W-1:0]        hold;
    logic                                 sn_rst;
  } lsr_sens_state_t;

  lsr_sens_state_t q;
  lsr_sens_state_t next_q;

  logic                            rise;
  logic [NUM_SEC-1:0]              start_in;
  logic [NUM_SEC-1:0]              active;
  logic [NUM_SEC-1:0][PIX_W-1:0]   level;

  // ****************************************************************
  // Input gathering
  // ****************************************************************
  assign start_in[0] = link.start_in_sec1;
  assign start_in[1] = link.start_in_sec2;
  assign level[0]    = px_level_sec1;
  assign level[1]    = px_level_sec2;

  // Only edges of sclk count; core_clk just samples it
  assign rise = link.sclk & ~q.sclk_q;

  // ****************************************************************
  // Output enable per section
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < NUM_SEC; g++)
    begin : g_sec
      // Period lasts while the start token sits in the register
      assign active[g] = |q.sr[g];
    end
  endgenerate

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    next_q        = q;
    next_q.sclk_q = link.sclk;

    // Reference level is restored at every rising sensor clock edge
    next_q.sn_rst = rise;

    for (int s = 0; s < NUM_SEC; s++)
    begin
      if (rise)
      begin
        if (q.sr[s][SEC_LAST])
        begin
          // 65th edge: token leaves, register cleared, output off
          next_q.sr[s]    = '0;
          next_q.sr[s][0] = start_in[s];
          next_q.idx[s]   = '0;
        end
        else if (!active[s])
        begin
          // Idle section waits for a start; all else is ignored
          next_q.sr[s][0] = start_in[s];
          next_q.idx[s]   = '0;
        end
        else
        begin
          // Mid-period starts are ignored so the token stays single
          next_q.sr[s]  = {q.sr[s][SEC_LAST-1:0], 1'b0};
          next_q.idx[s] = q.idx[s] + 1'b1;
        end
      end

      // Sample while sclk high, hold while low
      if (link.sclk && active[s])
      begin
        next_q.hold[s] = level[s];
      end
    end

    if (srst)
    begin
      next_q = '0;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    q <= next_q;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // In serial use section two is started by this pulse at edge 65
  assign link.pass_out_sec1  = q.sr[0][SEC_LAST];
  assign link.pass_out_sec2  = q.sr[1][SEC_LAST];
  assign link.pixel_out_sec1 = q.hold[0];
  assign link.pixel_out_sec2 = q.hold[1];
  assign link.pixel_oe_sec1  = active[0];
  assign link.pixel_oe_sec2  = active[1];
  assign px_addr_sec1        = q.idx[0];
  assign px_addr_sec2        = q.idx[1];
  assign sense_reset         = q.sn_rst;

endmodule

// *** rtl/lsr_ctrl_end.sv ***
// Controller end: derives the sensor clock, issues start pulses, counts
// readout edges and buffers captured pixels in a small FIFO.
// Assumes the sensor end shares core_clk and the link interface.
`timescale 1ns/1ps

// ****************************************************************
// Pixel FIFO
// ****************************************************************
module lsr_fifo
  import lsr_pkg::*;
#(
  parameter int W     = FIFO_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input  wire logic         core_clk,  // System clock
  input  wire logic         srst,      // Synchronous reset
  input  wire logic         in_valid,  // Write request
  output logic              in_ready,  // Space available
  input  wire logic [W-1:0] in_data,   // Write word
  output logic              out_valid, // Word available
  input  wire logic         out_ready, // Read accept
  output logic [W-1:0]      out_data   // Head word
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             cnt;
  } lsr_fifo_state_t;

  lsr_fifo_state_t q;
  lsr_fifo_state_t next_q;
  logic            do_wr;
  logic            do_rd;

  assign in_ready  = q.cnt != (AW+1)'(DEPTH);
  assign out_valid = q.cnt != '0;
  assign out_data  = q.mem[q.rd];
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;

  always_comb
  begin
    next_q = q;
    if (do_wr)
    begin
      next_q.mem[q.wr] = in_data;
      next_q.wr        = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
    end
    if (do_rd)
    begin
      next_q.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
    end
    next_q.cnt = q.cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    if (srst)
    begin
      next_q = '0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    q <= next_q;
  end
endmodule

// ****************************************************************
// Controller
// ****************************************************************
module lsr_ctrl_end
  import lsr_pkg::*;
(
  input  wire logic              core_clk,      // System clock
  input  wire logic              srst,          // Synchronous reset
  lsr_link_if.ctrl               link,          // Link to sensor
  input  wire logic              start_req,     // Pulse: one readout
  input  wire logic              flush_req,     // Pulse: flush cycles
  input  wire logic              parallel_mode, // High: parallel wiring
  input  wire logic [NSEC_W-1:0] num_sections,  // Sections in series
  output logic                   busy,          // Readout in progress
  output logic                   pix_valid,     // Pixel word available
  input  wire logic              pix_ready,     // Pixel word taken
  output logic [FIFO_W-1:0]      pix_data       // Parallel {oe2,oe1,pix2,pix1}; serial {0,1,0,analog}
);
  typedef enum logic [0:0] {ST_IDLE, ST_RUN} lsr_ctrl_st_t;

  typedef struct packed {
    lsr_ctrl_st_t      st;
    logic [PHASE_W-1:0] phase;
    logic              sclk;
    logic              start;
    logic [EDGE_W-1:0] edges;
    logic              quiet;
    logic [3:0]        flush_left;
    logic              req_read;
    logic              req_flush;
    logic              pend;
    logic [FIFO_W-1:0] pdata;
  } lsr_ctrl_state_t;

  lsr_ctrl_state_t   q;
  lsr_ctrl_state_t   next_q;
  logic              fifo_ready;
  logic              wrap;
  logic              stall;
  logic              fall;
  logic [EDGE_W-1:0] total;

  assign wrap  = q.phase == PHASE_LAST;
  // Clock held low until the last sample is buffered
  assign stall = q.pend & wrap;
  assign fall  = q.phase == PHASE_FALL;
  assign total = EDGE_W'(num_sections * SEC_PIXELS + EDGE_EXTRA);

  always_comb
  begin
    next_q           = q;
    next_q.req_read  = q.req_read | start_req;
    next_q.req_flush = q.req_flush | flush_req;
    if (q.pend && fifo_ready)
    begin
      next_q.pend = 1'b0;
    end
    if (!stall)
    begin
      next_q.phase = wrap ? '0 : q.phase + 1'b1;
    end
    next_q.sclk = next_q.phase < PHASE_HALF;
    if (wrap && !stall && q.st == ST_RUN)
    begin
      next_q.edges = q.edges + 1'b1;
    end

    // Sample after settling, once per sensor clock period
    if (q.phase == PHASE_SMP && !q.quiet && (link.pixel_oe_sec1 || link.pixel_oe_sec2))
    begin
      next_q.pend  = 1'b1;
      next_q.pdata = parallel_mode ?
        {link.pixel_oe_sec2, link.pixel_oe_sec1, link.pixel_out_sec2, link.pixel_out_sec1} :
        {1'b0, 1'b1, {PIX_W{1'b0}}, link.pixel_analog_out};
    end

    case (q.st)
      ST_IDLE:
      begin
        // Start rises at a falling edge, so it spans one rising edge
        if (fall && (q.req_read || q.req_flush))
        begin
          next_q.st         = ST_RUN;
          next_q.start      = 1'b1;
          next_q.edges      = '0;
          next_q.quiet      = q.req_flush;
          next_q.flush_left = q.req_flush ? FLUSH_CYCLES - 1'b1 : '0;
          // A request arriving in this very cycle is kept for the next run
          next_q.req_read   = start_req;
          next_q.req_flush  = flush_req;
        end
      end
      ST_RUN:
      begin
        if (fall)
        begin
          next_q.start = 1'b0;
          if (q.edges == total)
          begin
            if (q.flush_left != '0)
            begin
              // Restart so the next start is seen at edge n*64+2
              next_q.flush_left = q.flush_left - 1'b1;
              next_q.start      = 1'b1;
              next_q.edges      = '0;
            end
            else
            begin
              next_q.st    = ST_IDLE;
              next_q.quiet = 1'b0;
            end
          end
        end
      end
      default:
      begin
        next_q.st = ST_IDLE;
      end
    endcase

    if (srst)
    begin
      // Phase parks at the wrap so the first high phase is a full half period
      next_q       = '0;
      next_q.phase = PHASE_LAST;
    end
  end

  always_ff @(posedge core_clk)
  begin
    q <= next_q;
  end

  lsr_fifo #(
    .W     (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) lsr_fifo_inst (
    .core_clk  (core_clk),
    .srst      (srst),
    .in_valid  (q.pend),
    .in_ready  (fifo_ready),
    .in_data   (q.pdata),
    .out_valid (pix_valid),
    .out_ready (pix_ready),
    .out_data  (pix_data)
  );

  assign link.sclk          = q.sclk;
  assign link.start_in_sec1 = q.start;
  // Serial wiring chains section one's pass pulse into section two
  assign link.start_in_sec2 = parallel_mode ? q.start : link.pass_out_sec1;
  assign busy               = q.st != ST_IDLE;

endmodule

// *** verification/lsr_link_monitor.sv ***
// Concurrent checks on the link between controller end and sensor end.
// Assumes every link signal changes only on core_clk edges.
`timescale 1ns/1ps
module lsr_link_monitor
  import lsr_pkg::*;
(
  input wire logic             core_clk,       // Core clock
  input wire logic             srst,           // Sync reset
  input wire logic             sclk,           // Sensor clock
  input wire logic             start_in_sec1,  // Start, section one
  input wire logic             start_in_sec2,  // Start, section two
  input wire logic             pass_out_sec1,  // Pass, section one
  input wire logic             pass_out_sec2,  // Pass, section two
  input wire logic [PIX_W-1:0] pixel_out_sec1, // Pixel, section one
  input wire logic [PIX_W-1:0] pixel_out_sec2, // Pixel, section two
  input wire logic             pixel_oe_sec1,  // Enable, section one
  input wire logic             pixel_oe_sec2   // Enable, section two
);
  // ****************************************************************
  // Helper counters
  // ****************************************************************
  logic       sclk_q;
  logic [6:0] rise1;
  logic [6:0] rise2;
  logic [6:0] hi_cnt;
  wire        sclk_rise = sclk && !sclk_q;

  // Rises counted only while enabled, so the opening rise is excluded
  always_ff @(posedge core_clk)
  begin
    sclk_q <= srst ? 1'b0 : sclk;
    rise1  <= (srst || !pixel_oe_sec1) ? 7'h00 : rise1 + 7'(sclk_rise);
    rise2  <= (srst || !pixel_oe_sec2) ? 7'h00 : rise2 + 7'(sclk_rise);
    hi_cnt <= (srst || !sclk) ? 7'h00 : hi_cnt + 7'h01;
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_start_opens: assert property (sclk_rise && start_in_sec1 && !pixel_oe_sec1 |-> ##[1:2] pixel_oe_sec1)
    else $error("start did not open section one");
  a_pass_at_64: assert property ($rose(pass_out_sec1) |-> pixel_oe_sec1 && rise1 == 7'h3f)
    else $error("section one pass pulse off its cycle");
  a_pass2_at_64: assert property ($rose(pass_out_sec2) |-> pixel_oe_sec2 && rise2 == 7'h3f)
    else $error("section two pass pulse off its cycle");
  a_span_sec1: assert property ($fell(pixel_oe_sec1) |-> rise1 == 7'h40)
    else $error("section one enable span wrong");
  a_span_sec2: assert property ($fell(pixel_oe_sec2) |-> rise2 == 7'h40)
    else $error("section two enable span wrong");
  a_pass_drop: assert property ($fell(pass_out_sec1) |-> $fell(pixel_oe_sec1))
    else $error("pass pulse not cleared with enable");
  a_serial_handoff: assert property ($fell(pixel_oe_sec1) && $past(start_in_sec2) |-> $rose(pixel_oe_sec2))
    else $error("section two did not take over");
  a_hold_low: assert property (!sclk && !$past(sclk) && !$past(sclk, 2) |-> $stable({pixel_out_sec2, pixel_out_sec1}))
    else $error("pixel moved while clock low");
  a_start_on_fall: assert property ($changed(start_in_sec1) |-> $fell(sclk))
    else $error("start changed away from falling clock");
  a_clock_half: assert property ($fell(sclk) |-> hi_cnt == PHASE_HALF)
    else $error("sensor clock high phase wrong");

  c_serial: cover property ($rose(pixel_oe_sec2) && !pixel_oe_sec1);
  c_parallel: cover property ($rose(pixel_oe_sec1) && $rose(pixel_oe_sec2));
  c_pass2: cover property ($rose(pass_out_sec2));
endmodule

// *** verification/test_linear_sensor_readout_sequencer.sv ***
// Bench joining controller end and sensor end through the link.
// Assumes a 50 MHz core clock; pixel level is a function of its index.
`timescale 1ns/1ps
module test_linear_sensor_readout_sequencer
  import lsr_pkg::*;
();
  logic              core_clk = 1'b0;
  logic              srst = 1'b1;
  logic              start_req = 1'b0;
  logic              flush_req = 1'b0;
  logic              parallel_mode = 1'b0;
  logic [NSEC_W-1:0] num_sections = 4'h2;
  logic              pix_ready = 1'b1;
  logic              busy;
  logic              pix_valid;
  logic [FIFO_W-1:0] pix_data;
  logic [IDX_W-1:0]  addr1;
  logic [IDX_W-1:0]  addr2;
  logic              sense_reset;
  logic              sclk_q = 1'b0;
  int                n_errors = 0;
  int                total_checks = 0;
  int                n_rises = 0;
  int                n_sense = 0;
  int                mark;

  always #10 core_clk = ~core_clk;

  lsr_link_if link ();

  // Section two levels carry bit 6 so the two halves differ
  lsr_sensor_end lsr_sensor_end_inst (.core_clk(core_clk), .srst(srst), .link(link),
    .px_addr_sec1(addr1), .px_addr_sec2(addr2), .px_level_sec1({2'h0, addr1}),
    .px_level_sec2({2'h1, addr2}), .sense_reset(sense_reset));

  lsr_ctrl_end lsr_ctrl_end_inst (.core_clk(core_clk), .srst(srst), .link(link),
    .start_req(start_req), .flush_req(flush_req), .parallel_mode(parallel_mode),
    .num_sections(num_sections), .busy(busy), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .pix_data(pix_data));

  lsr_link_monitor lsr_link_monitor_inst (.core_clk(core_clk), .srst(srst), .sclk(link.sclk),
    .start_in_sec1(link.start_in_sec1), .start_in_sec2(link.start_in_sec2),
    .pass_out_sec1(link.pass_out_sec1), .pass_out_sec2(link.pass_out_sec2),
    .pixel_out_sec1(link.pixel_out_sec1), .pixel_out_sec2(link.pixel_out_sec2),
    .pixel_oe_sec1(link.pixel_oe_sec1), .pixel_oe_sec2(link.pixel_oe_sec2));

  always @(posedge core_clk)
  begin
    sclk_q <= link.sclk;
    if (link.sclk && !sclk_q)
      n_rises <= n_rises + 1;
    if (sense_reset)
      n_sense <= n_sense + 1;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_busy(input logic lvl);
    for (int i = 0; i < 20000; i++)
    begin
      @(negedge core_clk);
      if (busy === lvl)
        return;
    end
    check("busy wait", 32'h0, 32'(lvl) + 32'h2);
    print_verdict();
  endtask

  // Counts negedges until start reaches the level asked for
  task automatic wait_start(input logic lvl, output int cyc);
    for (cyc = 1; cyc <= 20000; cyc++)
    begin
      @(negedge core_clk);
      if (link.start_in_sec1 === lvl)
        return;
    end
    check("start wait", 32'h0, 32'(lvl) + 32'h2);
    print_verdict();
  endtask

  // Word is taken at the rising edge after it is seen
  task automatic get_word(input string what, input logic [17:0] exp);
    for (int i = 0; i < 20000; i++)
    begin
      @(negedge core_clk);
      if (pix_valid === 1'b1 && pix_ready === 1'b1)
      begin
        check(what, 32'(pix_data), 32'(exp));
        @(posedge core_clk);
        return;
      end
    end
    check("word wait", 32'h0, 32'h1);
    print_verdict();
  endtask

  task automatic pulse_start;
    @(posedge core_clk);
    start_req <= 1'b1;
    @(posedge core_clk);
    start_req <= 1'b0;
  endtask

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial
  begin
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    @(negedge core_clk);
    check("idle after reset", 32'({busy, pix_valid, link.start_in_sec1, link.pixel_oe_sec1,
      link.pixel_oe_sec2}), 32'h0);
    // Second request is queued behind the first
    pulse_start();
    wait_busy(1'b1);
    pulse_start();
    for (int k = 0; k < 256; k++)
      get_word("serial word", 18'h10000 | 18'(k % 128));
    wait_busy(1'b0);
    check("outputs off", 32'({link.pixel_oe_sec1, link.pixel_oe_sec2, pix_valid}), 32'h0);
    $display("Serial test done");
    @(posedge core_clk);
    parallel_mode <= 1'b1;
    num_sections <= 4'h1;
    pix_ready <= 1'b0;
    pulse_start();
    repeat (2000) @(negedge core_clk);
    mark = n_rises;
    repeat (1000) @(negedge core_clk);
    check("stalled clock rises", 32'(n_rises - mark), 32'h0);
    check("full fifo valid", 32'(pix_valid), 32'h1);
    @(posedge core_clk);
    pix_ready <= 1'b1;
    for (int k = 0; k < 64; k++)
      get_word("parallel word", {2'h3, 8'(k + 64), 8'(k)});
    wait_busy(1'b0);
    repeat (2) @(negedge core_clk);
    check("fifo drained", 32'(pix_valid), 32'h0);
    check("sense resets per rise", 32'(n_sense), 32'(n_rises));
    $display("Parallel stall test done");
    // Flush runs back to back with no data; a mid-run reset cuts it short
    @(posedge core_clk);
    flush_req <= 1'b1;
    @(posedge core_clk);
    flush_req <= 1'b0;
    wait_start(1'b1, mark);
    wait_start(1'b0, mark);
    check("start high span", 32'(mark), 32'(SCLK_PER_CYC));
    wait_start(1'b1, mark);
    // Restart seen at rise n*64+2, so start stays low for n*64 periods
    check("restart spacing", 32'(mark), 32'(SEC_PIXELS * SCLK_PER_CYC));
    check("flush data", 32'({busy, pix_valid}), 32'h2);
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    @(negedge core_clk);
    check("idle after second reset", 32'({busy, link.start_in_sec1, link.pixel_oe_sec1,
      link.pixel_oe_sec2}), 32'h0);
    $display("Flush and reset test done");
    print_verdict();
  end
endmodule
